// >>> rtl/sgs_gain_scheduler.sv
// Servo gain scheduler with AXI4-Lite configuration
// Functional notes
// - No switching unless tuning is manual mode
// - Model loop gain never switched
// - Inactive condition applies all base gains
// - Active condition uses alternate inertia ratio
// - Active condition uses alternate position/speed/integral
// - Low select digit picks condition, 1=external
// - External input mappable to any input pin
// - Threshold compared in source-specific unit
// - Switched gains move through first-order lag
// - Switched state under select 001 uses alternate vibration frequencies
// - Frequencies switch only under external condition
// - Select 001: input switches, release returns base
// - Select 003: droop magnitude controls switching
`timescale 1ns/100ps
module sgs_gain_scheduler
  import sgs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = FILTER_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,

  // AXI4-Lite write address
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,

  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,

  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,

  // AXI4-Lite read address
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,

  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,

  // Connector input pins
  input  wire logic [PIN_N-1:0]  io_connector,

  // Loop measurements
  input  wire logic [15:0]       cmd_freq,
  input  wire logic [31:0]       droop,
  input  wire logic [15:0]       motor_speed,

  // Active loop settings
  output logic [GAIN_W-1:0]      active_inertia,
  output logic [GAIN_W-1:0]      active_model_gain,
  output logic [GAIN_W-1:0]      active_position_gain,
  output logic [GAIN_W-1:0]      active_speed_gain,
  output logic [GAIN_W-1:0]      active_speed_integral,
  output logic [GAIN_W-1:0]      active_vib_freq,
  output logic [GAIN_W-1:0]      active_res_freq,
  output logic                   switch_state
);

  // Configuration storage
  logic [GAIN_W-1:0] cfg [NUM_CFG];

  // Write channel holding state
  logic              aw_full;
  logic [AXI_AW-1:0] aw_addr;
  logic              w_full;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  // Decoded access
  logic              do_write;
  logic              wr_cfg_hit;
  logic              wr_status_hit;
  logic [4:0]        wr_idx;
  logic              rd_cfg_hit;
  logic              rd_status_hit;
  logic [4:0]        rd_idx;
  logic [31:0]       rd_word;
  logic [1:0]        rd_resp;
  logic [1:0]        wr_resp;

  // Pin and condition state
  logic [PIN_N-1:0]  pin_meta;
  logic [PIN_N-1:0]  pin_sync;
  logic [2:0]        pin_sel;
  logic              ext_switch;
  logic              manual_mode;
  logic              freq_switch;
  logic [3:0]        status;

  // Filter timing
  logic [31:0]       tick_cnt;
  logic              tick;
  logic              load_pending;

  // Gain targets
  logic [GAIN_W-1:0] tgt_inertia;
  logic [GAIN_W-1:0] tgt_position;
  logic [GAIN_W-1:0] tgt_speed;
  logic [GAIN_W-1:0] tgt_integral;

  sgs_cond_if cond ();

  function automatic logic [4:0] sgs_word_idx(input logic [AXI_AW-1:0] a);
    sgs_word_idx = a[6:2];
  endfunction

  // Handshake outputs
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_full && w_full && !s_axi_bvalid;

  // Write address decode
  assign wr_idx = sgs_word_idx(aw_addr);
  assign wr_cfg_hit    = (aw_addr < OFS_CFG_END) && (aw_addr[1:0] == 2'h0);
  assign wr_status_hit = (aw_addr == OFS_STATUS);
  assign wr_resp       = (wr_cfg_hit || wr_status_hit) ? RESP_OKAY : RESP_SLVERR;

  // Read address decode
  assign rd_idx = sgs_word_idx(s_axi_araddr);
  assign rd_cfg_hit    = (s_axi_araddr < OFS_CFG_END) && (s_axi_araddr[1:0] == 2'h0);
  assign rd_status_hit = (s_axi_araddr == OFS_STATUS);
  assign rd_resp       = (rd_cfg_hit || rd_status_hit) ? RESP_OKAY : RESP_SLVERR;
  assign rd_word       = rd_cfg_hit    ? {16'h0000, cfg[rd_idx]} :
                         rd_status_hit ? {28'h0000000, status} :
                         32'h00000000;

  // Write channel capture
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_resp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read response
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration words with byte strobes on the low half
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg[IDX_TUNING]     <= RST_TUNING;
      cfg[IDX_SELECT]     <= RST_SELECT;
      cfg[IDX_THRESHOLD]  <= RST_THRESHOLD;
      cfg[IDX_TIME_CONST] <= RST_TIME_CONST;
      cfg[IDX_INPUT_MAP]  <= RST_INPUT_MAP;
      cfg[IDX_INERTIA_B]  <= RST_INERTIA_B;
      cfg[IDX_MODEL_GAIN] <= RST_MODEL_GAIN;
      cfg[IDX_POS_B]      <= RST_POS_B;
      cfg[IDX_SPEED_B]    <= RST_SPEED_B;
      cfg[IDX_INTEG_B]    <= RST_INTEG_B;
      cfg[IDX_INERTIA_A]  <= RST_INERTIA_A;
      cfg[IDX_POS_A]      <= RST_POS_A;
      cfg[IDX_SPEED_A]    <= RST_SPEED_A;
      cfg[IDX_INTEG_A]    <= RST_INTEG_A;
      cfg[IDX_VIB_B]      <= RST_VIB_B;
      cfg[IDX_RES_B]      <= RST_RES_B;
      cfg[IDX_VIB_A]      <= RST_VIB_A;
      cfg[IDX_RES_A]      <= RST_RES_A;
    end else if (do_write && wr_cfg_hit) begin
      if (w_strb[0]) begin
        cfg[wr_idx][7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        cfg[wr_idx][15:8] <= w_data[15:8];
      end
    end
  end

  // Connector pins pass two flip-flops before use
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= io_connector;
      pin_sync <= pin_meta;
    end
  end

  // External switch input routed to the configured pin
  assign pin_sel    = (cfg[IDX_INPUT_MAP][2:0] < 3'(PIN_N)) ? cfg[IDX_INPUT_MAP][2:0] : 3'h0;
  assign ext_switch = pin_sync[pin_sel];

  // Condition evaluation
  assign cond.sel         = cfg[IDX_SELECT][3:0];
  assign cond.threshold   = cfg[IDX_THRESHOLD];
  assign cond.cmd_freq    = cmd_freq;
  assign cond.droop       = droop;
  assign cond.motor_speed = motor_speed;
  assign cond.ext_in      = ext_switch;

  sgs_switch_cond u_cond (
    .ref_clk (ref_clk),
    .srst    (srst),
    .cond    (cond)
  );

  // Switching is held off outside manual tuning
  assign manual_mode  = (cfg[IDX_TUNING][3:0] == TUNING_MANUAL);
  assign switch_state = cond.active && manual_mode;
  assign freq_switch  = switch_state && (cfg[IDX_SELECT][3:0] == COND_EXT);
  assign status       = {freq_switch, manual_mode, switch_state, cond.active};

  // Gain targets: base while inactive, alternate while active
  assign tgt_inertia  = switch_state ? cfg[IDX_INERTIA_A] : cfg[IDX_INERTIA_B];
  assign tgt_position = switch_state ? cfg[IDX_POS_A] : cfg[IDX_POS_B];
  assign tgt_speed    = switch_state ? cfg[IDX_SPEED_A] : cfg[IDX_SPEED_B];
  assign tgt_integral = switch_state ? cfg[IDX_INTEG_A] : cfg[IDX_INTEG_B];

  // Model gain bypasses switching entirely
  assign active_model_gain = cfg[IDX_MODEL_GAIN];

  // Vibration suppression frequencies, switched without filtering
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      active_vib_freq <= RST_VIB_B;
      active_res_freq <= RST_RES_B;
    end else begin
      active_vib_freq <= freq_switch ? cfg[IDX_VIB_A] : cfg[IDX_VIB_B];
      active_res_freq <= freq_switch ? cfg[IDX_RES_A] : cfg[IDX_RES_B];
    end
  end

  // Millisecond tick for the lag filters
  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  // Filters snap to target once after reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= 1'b0;
    end
  end

  sgs_lag_filter #(.W(GAIN_W), .FRAC(16)) u_lag_inertia (
    .ref_clk (ref_clk),
    .srst    (srst),
    .load    (load_pending),
    .tick    (tick),
    .tc_ms   (cfg[IDX_TIME_CONST]),
    .target  (tgt_inertia),
    .value   (active_inertia)
  );

  sgs_lag_filter #(.W(GAIN_W), .FRAC(16)) u_lag_position (
    .ref_clk (ref_clk),
    .srst    (srst),
    .load    (load_pending),
    .tick    (tick),
    .tc_ms   (cfg[IDX_TIME_CONST]),
    .target  (tgt_position),
    .value   (active_position_gain)
  );

  sgs_lag_filter #(.W(GAIN_W), .FRAC(16)) u_lag_speed (
    .ref_clk (ref_clk),
    .srst    (srst),
    .load    (load_pending),
    .tick    (tick),
    .tc_ms   (cfg[IDX_TIME_CONST]),
    .target  (tgt_speed),
    .value   (active_speed_gain)
  );

  sgs_lag_filter #(.W(GAIN_W), .FRAC(16)) u_lag_integral (
    .ref_clk (ref_clk),
    .srst    (srst),
    .load    (load_pending),
    .tick    (tick),
    .tc_ms   (cfg[IDX_TIME_CONST]),
    .target  (tgt_integral),
    .value   (active_speed_integral)
  );

endmodule

// >>> rtl/sgs_pkg.sv
// Shared constants for the servo gain scheduler
package sgs_pkg;

  // Data widths
  localparam int GAIN_W = 16;
  localparam int AXI_AW = 8;
  localparam int PIN_N  = 6;

  // Configuration word indices (byte offset is four times the index)
  localparam int IDX_TUNING     = 0;
  localparam int IDX_SELECT     = 1;
  localparam int IDX_THRESHOLD  = 2;
  localparam int IDX_TIME_CONST = 3;
  localparam int IDX_INPUT_MAP  = 4;
  localparam int IDX_INERTIA_B  = 5;
  localparam int IDX_MODEL_GAIN = 6;
  localparam int IDX_POS_B      = 7;
  localparam int IDX_SPEED_B    = 8;
  localparam int IDX_INTEG_B    = 9;
  localparam int IDX_INERTIA_A  = 10;
  localparam int IDX_POS_A      = 11;
  localparam int IDX_SPEED_A    = 12;
  localparam int IDX_INTEG_A    = 13;
  localparam int IDX_VIB_B      = 14;
  localparam int IDX_RES_B      = 15;
  localparam int IDX_VIB_A      = 16;
  localparam int IDX_RES_A      = 17;
  localparam int NUM_CFG        = 18;

  // Byte offsets
  localparam logic [AXI_AW-1:0] OFS_CFG_END = 8'h48;
  localparam logic [AXI_AW-1:0] OFS_STATUS  = 8'h48;

  // Status bit positions
  localparam int ST_COND   = 0;
  localparam int ST_SWITCH = 1;
  localparam int ST_MANUAL = 2;
  localparam int ST_FREQSW = 3;

  // Field values
  localparam logic [3:0] TUNING_MANUAL = 4'h3;
  localparam logic [3:0] COND_NONE     = 4'h0;
  localparam logic [3:0] COND_EXT      = 4'h1;
  localparam logic [3:0] COND_FREQ     = 4'h2;
  localparam logic [3:0] COND_DROOP    = 4'h3;
  localparam logic [3:0] COND_SPEED    = 4'h4;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [GAIN_W-1:0] RST_TUNING     = 16'h0003;
  localparam logic [GAIN_W-1:0] RST_SELECT     = 16'h0001;
  localparam logic [GAIN_W-1:0] RST_THRESHOLD  = 16'h0032;
  localparam logic [GAIN_W-1:0] RST_TIME_CONST = 16'h0064;
  localparam logic [GAIN_W-1:0] RST_INPUT_MAP  = 16'h0000;
  localparam logic [GAIN_W-1:0] RST_INERTIA_B  = 16'h0028;
  localparam logic [GAIN_W-1:0] RST_MODEL_GAIN = 16'h0064;
  localparam logic [GAIN_W-1:0] RST_POS_B      = 16'h0078;
  localparam logic [GAIN_W-1:0] RST_SPEED_B    = 16'h0bb8;
  localparam logic [GAIN_W-1:0] RST_INTEG_B    = 16'h0014;
  localparam logic [GAIN_W-1:0] RST_INERTIA_A  = 16'h0064;
  localparam logic [GAIN_W-1:0] RST_POS_A      = 16'h0054;
  localparam logic [GAIN_W-1:0] RST_SPEED_A    = 16'h0fa0;
  localparam logic [GAIN_W-1:0] RST_INTEG_A    = 16'h0032;
  localparam logic [GAIN_W-1:0] RST_VIB_B      = 16'h0032;
  localparam logic [GAIN_W-1:0] RST_RES_B      = 16'h0032;
  localparam logic [GAIN_W-1:0] RST_VIB_A      = 16'h003c;
  localparam logic [GAIN_W-1:0] RST_RES_A      = 16'h003c;

  // Filter time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int FILTER_TICK_NS = 1000000;
  localparam int FILTER_TICK_CYCLES = FILTER_TICK_NS / CLK_PERIOD_NS;

endpackage

// >>> rtl/sgs_cond_if.sv
// Switch condition carrier between top and condition evaluator
`timescale 1ns/100ps
interface sgs_cond_if;
  import sgs_pkg::*;
  logic [3:0]        sel;
  logic [GAIN_W-1:0] threshold;
  logic [15:0]       cmd_freq;
  logic [31:0]       droop;
  logic [15:0]       motor_speed;
  logic              ext_in;
  logic              active;
  modport top  (output sel, threshold, cmd_freq, droop, motor_speed, ext_in, input active);
  modport eval (input sel, threshold, cmd_freq, droop, motor_speed, ext_in, output active);
endinterface

// >>> rtl/sgs_switch_cond.sv
// Evaluates the selected gain switch condition
`timescale 1ns/100ps
module sgs_switch_cond
  import sgs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Condition carrier
  sgs_cond_if.eval cond
);

  function automatic logic [31:0] sgs_mag(input logic [31:0] v);
    sgs_mag = v[31] ? 32'(-v) : v;
  endfunction

  logic [31:0] thr;
  logic [31:0] freq_mag;
  logic [31:0] droop_mag;
  logic [31:0] speed_mag;
  logic        next_active;

  assign thr       = {16'h0000, cond.threshold};
  assign freq_mag  = {16'h0000, cond.cmd_freq};
  assign droop_mag = sgs_mag(cond.droop);
  assign speed_mag = sgs_mag({{16{cond.motor_speed[15]}}, cond.motor_speed});

  // Level conditions hold while magnitude is at or above threshold
  assign next_active = (cond.sel == COND_EXT)   ? cond.ext_in :
                       (cond.sel == COND_FREQ)  ? (freq_mag >= thr) :
                       (cond.sel == COND_DROOP) ? (droop_mag >= thr) :
                       (cond.sel == COND_SPEED) ? (speed_mag >= thr) :
                       1'b0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cond.active <= 1'b0;
    end else begin
      cond.active <= next_active;
    end
  end

endmodule

// >>> rtl/sgs_lag_filter.sv
// First-order lag filter stepping once per tick
`timescale 1ns/100ps
module sgs_lag_filter #(
  parameter int W    = 16,
  parameter int FRAC = 16
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         srst,
  // Control
  input  wire logic         load,
  input  wire logic         tick,
  input  wire logic [W-1:0] tc_ms,
  // Data
  input  wire logic [W-1:0] target,
  output logic      [W-1:0] value
);

  localparam int AW = W + FRAC + 2;

  logic signed [AW-1:0] acc;
  logic signed [AW-1:0] diff;
  logic signed [AW-1:0] divisor;
  logic signed [AW-1:0] stepq;
  logic signed [AW-1:0] step;
  logic signed [AW-1:0] target_fx;

  assign target_fx = $signed({2'b00, target, {FRAC{1'b0}}});
  assign diff      = target_fx - acc;
  assign divisor   = (tc_ms == '0) ? AW'(1) : $signed({{(AW-W){1'b0}}, tc_ms});
  assign stepq     = diff / divisor;
  // Minimum step of one LSB so the output lands exactly on target
  assign step      = (stepq != '0) ? stepq : (diff > 0) ? AW'(1) : (diff < 0) ? -AW'(1) : '0;
  assign value     = acc[FRAC+W-1:FRAC];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc <= '0;
    end else if (load || tc_ms == '0) begin
      acc <= target_fx;
    end else if (tick) begin
      acc <= acc + step;
    end
  end

endmodule

// >>> tb/sgs_loop_model.sv
// Far-side model: loop measurements and connector pins
`timescale 1ns/100ps
module sgs_loop_model
  import sgs_pkg::*;
(
  // Clock
  input  wire logic             ref_clk,
  // Bench commands
  input  wire logic             ext_on,
  input  wire logic [2:0]       pin_sel,
  input  wire logic [31:0]      droop_set,
  input  wire logic [15:0]      speed_set,
  input  wire logic [15:0]      freq_set,
  // Pins and measurements
  output logic      [PIN_N-1:0] io_connector,
  output logic      [31:0]      droop,
  output logic      [15:0]      motor_speed,
  output logic      [15:0]      cmd_freq
);
  logic [PIN_N-1:0] one_hot;
  assign one_hot = PIN_N'(1) << pin_sel;
  initial begin
    io_connector = '0;
    droop = '0;
    motor_speed = '0;
    cmd_freq = '0;
  end
  // Unselected pins carry the opposite level so a wrong mapping shows
  always @(posedge ref_clk) begin
    io_connector <= ext_on ? one_hot : ~one_hot;
    droop <= droop_set;
    motor_speed <= speed_set;
    cmd_freq <= freq_set;
  end
endmodule

// >>> tb/sgs_properties.sv
// Port-level property checker for the gain scheduler
`timescale 1ns/100ps
module sgs_properties
  import sgs_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              srst,
  // Register bus
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  // Loop side
  input wire logic [PIN_N-1:0]  io_connector,
  input wire logic [15:0]       cmd_freq,
  input wire logic [31:0]       droop,
  input wire logic [15:0]       motor_speed,
  input wire logic [GAIN_W-1:0] active_model_gain,
  input wire logic [GAIN_W-1:0] active_vib_freq,
  input wire logic [GAIN_W-1:0] active_res_freq,
  input wire logic              switch_state
);
  logic [AXI_AW-1:0] wa;
  logic [15:0]       wd, tun_sh, sel_sh, thr_sh, map_sh, smag;
  logic [31:0]       dmag, meas;
  logic              aw_got, w_got, commit, manual, ext_ok, lvl_ok, ext_lvl;

  // Shadow of the steering settings, committed on the same edge as the write
  assign commit = aw_got & w_got;
  assign manual = tun_sh[3:0] == TUNING_MANUAL;
  assign ext_lvl = io_connector[(map_sh[2:0] > 3'h5) ? 3'h0 : map_sh[2:0]];
  assign ext_ok = manual && !commit && sel_sh[3:0] == COND_EXT;
  assign lvl_ok = manual && !commit && sel_sh[3:0] inside {COND_FREQ, COND_DROOP, COND_SPEED};
  assign dmag = droop[31] ? -droop : droop;
  assign smag = motor_speed[15] ? -motor_speed : motor_speed;
  assign meas = (sel_sh[3:0] == COND_FREQ) ? {16'h0000, cmd_freq} :
                (sel_sh[3:0] == COND_DROOP) ? dmag : {16'h0000, smag};
  always_ff @(posedge ref_clk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[15:0];
  end
  always_ff @(posedge ref_clk) begin
    if (srst || commit) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_got <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_got <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tun_sh <= RST_TUNING;
      sel_sh <= RST_SELECT;
      thr_sh <= RST_THRESHOLD;
      map_sh <= RST_INPUT_MAP;
    end else if (commit) begin
      case (wa)
        8'h00: tun_sh <= wd;
        8'h04: sel_sh <= wd;
        8'h08: thr_sh <= wd;
        8'h10: map_sh <= wd;
        default: ;
      endcase
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_tuning_blocks: assert property (!manual |-> !switch_state)
    else $error("switching while tuning not manual");
  a_model_fixed: assert property ($changed(active_model_gain) |-> $past(commit) && $past(wa) == 8'h18)
    else $error("model gain moved without its write");
  a_ext_on: assert property (ext_ok && $rose(ext_lvl) ##1 (ext_ok && ext_lvl)[*2] |=> switch_state)
    else $error("input high did not switch");
  a_ext_off: assert property (ext_ok && $fell(ext_lvl) ##1 (ext_ok && !ext_lvl)[*2] |=> !switch_state)
    else $error("input low did not return");
  a_level_cond: assert property (lvl_ok && $past(lvl_ok) |->
    switch_state == ($past(meas) >= {16'h0000, $past(thr_sh)}))
    else $error("level condition wrong");
  a_freq_hold: assert property (lvl_ok && $past(lvl_ok) && $past(lvl_ok, 2) |->
    $stable(active_vib_freq) && $stable(active_res_freq))
    else $error("frequencies moved under level condition");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule

bind sgs_gain_scheduler sgs_properties sgs_properties_i (.*);

// >>> tb/tb.sv
// Self-checking bench for the gain scheduler
`timescale 1ns/100ps
module tb
  import sgs_pkg::*;
;
  localparam int TICK = 10;
  localparam int LIMIT = 60000;
  logic              ref_clk, srst, ext_on, switch_state;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]        s_axi_awprot, s_axi_arprot, pin_sel;
  logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0]       s_axi_wdata, s_axi_rdata, droop, droop_set;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [PIN_N-1:0]  io_connector;
  logic [15:0]       cmd_freq, motor_speed, speed_set, freq_set;
  logic [GAIN_W-1:0] active_inertia, active_model_gain, active_position_gain, active_speed_gain;
  logic [GAIN_W-1:0] active_speed_integral, active_vib_freq, active_res_freq;
  int                num_errors = 0;
  int                checks = 0;
  int                cycles = 0;

  sgs_gain_scheduler #(.TICK_CYCLES(TICK)) sgs_gain_scheduler_i (.*);
  sgs_loop_model sgs_loop_model_i (.*);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input int idx, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= AXI_AW'(4 * idx);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask

  task automatic rd(input int idx, input logic [31:0] ex, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= AXI_AW'(4 * idx);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ex);
    check(s_axi_rresp, er);
  endtask

  // Waits for the filtered speed and position gains to reach their targets
  task automatic settle(input logic [15:0] spd, input logic [15:0] pos);
    for (int i = 0; i < 20000 && (active_speed_gain !== spd || active_position_gain !== pos); i++)
      @(posedge ref_clk);
    tick(2 * TICK);
  endtask

  task automatic t_reset;
    rd(IDX_MODEL_GAIN, RST_MODEL_GAIN, RESP_OKAY);
    wr(IDX_MODEL_GAIN, RST_MODEL_GAIN + 1, RESP_OKAY);
    check(active_model_gain, RST_MODEL_GAIN + 1);
    rd(IDX_INERTIA_A, RST_INERTIA_A, RESP_OKAY);
    rd(NUM_CFG, 32'h1 << ST_MANUAL, RESP_OKAY);
    rd(NUM_CFG + 1, 32'h0, RESP_SLVERR);
    wr(NUM_CFG + 1, 32'h1234, RESP_SLVERR);
    check(active_inertia, RST_INERTIA_B);
    check(active_position_gain, RST_POS_B);
    check(active_speed_gain, RST_SPEED_B);
    check(active_speed_integral, RST_INTEG_B);
    check(active_vib_freq, RST_VIB_B);
    check(switch_state, 1'b0);
  endtask

  task automatic t_ext;
    wr(IDX_TIME_CONST, 32'ha, RESP_OKAY);
    wr(IDX_INPUT_MAP, 32'h4, RESP_OKAY);
    pin_sel <= 3'h4;
    tick(6);
    check(switch_state, 1'b0);
    ext_on <= 1'b1;
    tick(6);
    check(switch_state, 1'b1);
    check(active_vib_freq, RST_VIB_A);
    check(active_res_freq, RST_RES_A);
    tick(3 * TICK);
    check(active_position_gain < RST_POS_B && active_position_gain > RST_POS_A, 1'b1);
    settle(RST_SPEED_A, RST_POS_A);
    check(active_inertia, RST_INERTIA_A);
    check(active_position_gain, RST_POS_A);
    check(active_speed_integral, RST_INTEG_A);
    check(active_model_gain, RST_MODEL_GAIN + 1);
    ext_on <= 1'b0;
    tick(6);
    check(switch_state, 1'b0);
    check(active_res_freq, RST_RES_B);
    settle(RST_SPEED_B, RST_POS_B);
    check(active_position_gain, RST_POS_B);
    check(active_inertia, RST_INERTIA_B);
  endtask

  task automatic t_level;
    wr(IDX_INERTIA_A, RST_INERTIA_B, RESP_OKAY);
    for (int s = 0; s < 5; s++) begin
      if (s == 1) continue;
      wr(IDX_SELECT, s, RESP_OKAY);
      for (int v = 49; v < 51; v++) begin
        droop_set <= -v;
        speed_set <= 16'(v);
        freq_set <= 16'(v);
        tick(4);
        check(switch_state, s != 0 && v >= 50);
        check(active_vib_freq, RST_VIB_B);
      end
    end
    settle(RST_SPEED_A, RST_POS_A);
    check(active_inertia, RST_INERTIA_B);
    check(active_position_gain, RST_POS_A);
    droop_set <= '0;
    speed_set <= '0;
    freq_set <= '0;
  endtask

  task automatic t_tuning;
    wr(IDX_SELECT, COND_EXT, RESP_OKAY);
    ext_on <= 1'b1;
    tick(6);
    check(switch_state, 1'b1);
    wr(IDX_TUNING, 32'h0, RESP_OKAY);
    tick(2);
    check(switch_state, 1'b0);
    settle(RST_SPEED_B, RST_POS_B);
    check(active_position_gain, RST_POS_B);
    wr(IDX_TUNING, TUNING_MANUAL, RESP_OKAY);
    tick(2);
    check(switch_state, 1'b1);
    ext_on <= 1'b0;
  endtask

  initial begin
    srst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {ext_on, pin_sel, droop_set, speed_set, freq_set} = '0;
    tick(8);
    srst <= 1'b0;
    tick(2);
    t_reset();
    t_ext();
    t_level();
    t_tuning();
    give_verdict();
  end
endmodule
